// ### rtl/plc_regs.sv
// Purpose: APB register bank steering synthesizer loop controls and settle timing
// Assumes: Single clock pclk at 20 MHz, asynchronous active-low reset
// Notes: Long settle counts are parameters so a bench can shorten them
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
module plc_regs
    import plc_pkg::*;
#(
    parameter int LOOP_WAIT1_CYCLES = LOOP_WAIT1_CYC,
    parameter int LOOP_WAIT2_CYCLES = LOOP_WAIT2_CYC,
    parameter int LOOP_WAIT3_CYCLES = LOOP_WAIT3_CYC,
    parameter int OSC_WAIT1_CYCLES = OSC_WAIT1_CYC,
    parameter int OSC_WAIT2_CYCLES = OSC_WAIT2_CYC,
    parameter int OSC_WAIT3_CYCLES = OSC_WAIT3_CYC
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog loop controls
    output logic [2:0] synth_a_filter_order_sel,
    output logic synth_a_narrow_bandwidth,
    output logic synth_b_pump_width_extend,
    // Settle sequence status
    output logic cal_busy
);

    // A zero count would underflow the down-counter and stall the sequence for ages
    if (LOOP_WAIT1_CYCLES < 1 || LOOP_WAIT2_CYCLES < 1 || LOOP_WAIT3_CYCLES < 1 ||
        OSC_WAIT1_CYCLES < 1 || OSC_WAIT2_CYCLES < 1 || OSC_WAIT3_CYCLES < 1)
    begin : g_wait_check
        $error("plc_regs: wait counts must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic [9:0] idx;
    logic setup;
    logic wr_en;
    logic hit;
    assign idx = paddr[11:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready;
    assign hit = (idx == IDX_FILTER_ORDER) || (idx == IDX_CAL_WAITS) ||
                 (idx == IDX_BANDWIDTH) || (idx == IDX_CAL_CONTROL) ||
                 (idx == IDX_PUMP_WIDTH);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Control registers

    logic [1:0] closed_loop_settle;
    logic [1:0] osc_settle;
    logic [2:0] next_filter_order;
    logic [1:0] next_closed_loop_settle;
    logic [1:0] next_osc_settle;
    logic next_narrow_bw;
    logic next_pump_extend;
    logic cal_start;

    always_comb
    begin
        next_filter_order = synth_a_filter_order_sel;
        next_closed_loop_settle = closed_loop_settle;
        next_osc_settle = osc_settle;
        next_narrow_bw = synth_a_narrow_bandwidth;
        next_pump_extend = synth_b_pump_width_extend;
        cal_start = 1'b0;
        if (wr_en)
        begin
            // Only defined field bits are stored; reserved bits are dropped
            case (idx)
                IDX_FILTER_ORDER: next_filter_order = pwdata[FILTER_ORDER_LSB +: 3];
                IDX_CAL_WAITS:
                begin
                    next_closed_loop_settle = pwdata[CLOSED_LOOP_SETTLE_LSB +: 2];
                    next_osc_settle = pwdata[OSC_SETTLE_LSB +: 2];
                end
                IDX_BANDWIDTH: next_narrow_bw = pwdata[NARROW_BW_BIT];
                IDX_PUMP_WIDTH: next_pump_extend = pwdata[PUMP_EXTEND_BIT];
                IDX_CAL_CONTROL: cal_start = pwdata[CAL_START_BIT];
                default: cal_start = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            synth_a_filter_order_sel <= FILTER_ORDER_RST;
            closed_loop_settle <= CLOSED_LOOP_SETTLE_RST;
            osc_settle <= OSC_SETTLE_RST;
            synth_a_narrow_bandwidth <= NARROW_BW_RST;
            synth_b_pump_width_extend <= PUMP_EXTEND_RST;
        end
        else
        begin
            synth_a_filter_order_sel <= next_filter_order;
            closed_loop_settle <= next_closed_loop_settle;
            osc_settle <= next_osc_settle;
            synth_a_narrow_bandwidth <= next_narrow_bw;
            synth_b_pump_width_extend <= next_pump_extend;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Settle sequence: oscillator wait, then closed-loop wait

    function automatic logic [31:0] loop_cycles(input logic [1:0] code);
        case (code)
            2'h0: loop_cycles = 32'(LOOP_WAIT0_CYC);
            2'h1: loop_cycles = 32'(LOOP_WAIT1_CYCLES);
            2'h2: loop_cycles = 32'(LOOP_WAIT2_CYCLES);
            default: loop_cycles = 32'(LOOP_WAIT3_CYCLES);
        endcase
    endfunction : loop_cycles

    function automatic logic [31:0] osc_cycles(input logic [1:0] code);
        case (code)
            2'h0: osc_cycles = 32'(OSC_WAIT0_CYC);
            2'h1: osc_cycles = 32'(OSC_WAIT1_CYCLES);
            2'h2: osc_cycles = 32'(OSC_WAIT2_CYCLES);
            default: osc_cycles = 32'(OSC_WAIT3_CYCLES);
        endcase
    endfunction : osc_cycles

    plc_cal_state_t state;
    plc_cal_state_t next_state;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [1:0] loop_code;
    logic [1:0] next_loop_code;
    logic cal_done;
    logic next_cal_done;

    // Codes are latched at start so a rewrite mid-sequence cannot shorten a wait
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_loop_code = loop_code;
        next_cal_done = cal_done;
        case (state)
            CAL_IDLE:
            begin
                if (cal_start)
                begin
                    next_state = CAL_OSC_WAIT;
                    next_cnt = osc_cycles(osc_settle) - 32'h00000001;
                    next_loop_code = closed_loop_settle;
                    next_cal_done = 1'b0;
                end
            end
            CAL_OSC_WAIT:
            begin
                if (cnt == 32'h00000000)
                begin
                    next_state = CAL_LOOP_WAIT;
                    next_cnt = loop_cycles(loop_code) - 32'h00000001;
                end
                else
                begin
                    next_cnt = cnt - 32'h00000001;
                end
            end
            CAL_LOOP_WAIT:
            begin
                if (cnt == 32'h00000000)
                begin
                    next_state = CAL_IDLE;
                    next_cal_done = 1'b1;
                end
                else
                begin
                    next_cnt = cnt - 32'h00000001;
                end
            end
            default: next_state = CAL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= CAL_IDLE;
            cnt <= 32'h00000000;
            loop_code <= CLOSED_LOOP_SETTLE_RST;
            cal_done <= 1'b0;
            cal_busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            loop_code <= next_loop_code;
            cal_done <= next_cal_done;
            cal_busy <= (next_state != CAL_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read path, answered with no wait state

    logic [DATA_W-1:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        case (idx)
            IDX_FILTER_ORDER: rd_mux[FILTER_ORDER_LSB +: 3] = synth_a_filter_order_sel;
            IDX_CAL_WAITS:
            begin
                rd_mux[CLOSED_LOOP_SETTLE_LSB +: 2] = closed_loop_settle;
                rd_mux[OSC_SETTLE_LSB +: 2] = osc_settle;
            end
            IDX_BANDWIDTH: rd_mux[NARROW_BW_BIT] = synth_a_narrow_bandwidth;
            IDX_PUMP_WIDTH: rd_mux[PUMP_EXTEND_BIT] = synth_b_pump_width_extend;
            IDX_CAL_CONTROL:
            begin
                rd_mux[CAL_BUSY_BIT] = cal_busy;
                rd_mux[CAL_DONE_BIT] = cal_done;
            end
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= (setup && !pwrite) ? rd_mux : '0;
            pready <= setup;
            pslverr <= setup && !hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic first_cyc;
    logic [31:0] osc_run;
    logic [31:0] loop_run;
    logic [1:0] osc_code_seen;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_cyc <= 1'b1;
            osc_run <= 32'h00000000;
            loop_run <= 32'h00000000;
            osc_code_seen <= 2'h0;
        end
        else
        begin
            first_cyc <= 1'b0;
            osc_run <= (state == CAL_OSC_WAIT) ? osc_run + 32'h00000001 : 32'h00000000;
            loop_run <= (state == CAL_LOOP_WAIT) ? loop_run + 32'h00000001 : 32'h00000000;
            if (cal_start && state == CAL_IDLE)
            begin
                osc_code_seen <= osc_settle;
            end
        end
    end

    property p_filter_write;
        @(posedge pclk) disable iff (!presetn)
        wr_en && idx == IDX_FILTER_ORDER |=> synth_a_filter_order_sel == $past(pwdata[2:0]);
    endproperty
    a_filter_write: assert property (p_filter_write) else $error("filter order lost");

    property p_loop_wait;
        @(posedge pclk) disable iff (!presetn)
        state == CAL_LOOP_WAIT && next_state == CAL_IDLE |->
            loop_run + 32'h00000001 == loop_cycles(loop_code);
    endproperty
    a_loop_wait: assert property (p_loop_wait) else $error("loop wait length wrong");

    property p_osc_wait;
        @(posedge pclk) disable iff (!presetn)
        state == CAL_OSC_WAIT && next_state == CAL_LOOP_WAIT |->
            osc_run + 32'h00000001 == osc_cycles(osc_code_seen);
    endproperty
    a_osc_wait: assert property (p_osc_wait) else $error("oscillator wait length wrong");

    property p_reset_vals;
        @(posedge pclk) disable iff (!presetn)
        first_cyc |-> synth_a_filter_order_sel == 3'h3 && closed_loop_settle == 2'h0 &&
            osc_settle == 2'h1;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    property p_bw_write;
        @(posedge pclk) disable iff (!presetn)
        wr_en && idx == IDX_BANDWIDTH |=> synth_a_narrow_bandwidth == $past(pwdata[0]) && !pready;
    endproperty
    a_bw_write: assert property (p_bw_write) else $error("bandwidth bit not stored");

    property p_pump_write;
        @(posedge pclk) disable iff (!presetn)
        wr_en && idx == IDX_PUMP_WIDTH |=> synth_b_pump_width_extend == $past(pwdata[7]);
    endproperty
    a_pump_write: assert property (p_pump_write) else $error("pump width bit not stored");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && idx == IDX_FILTER_ORDER |=> pready && prdata[31:3] == 29'h0000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

endmodule : plc_regs

// ### rtl/plc_pkg.sv
// Purpose: Shared constants for the synthesizer loop control register bank
// Assumes: APB with 32-bit data, pclk at 20 MHz
// Notes: Register indices are kept as printed; byte address is four times the index
package plc_pkg;
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register indices
    localparam logic [9:0] IDX_FILTER_ORDER = 10'h076;
    localparam logic [9:0] IDX_CAL_WAITS = 10'h077;
    localparam logic [9:0] IDX_BANDWIDTH = 10'h078;
    localparam logic [9:0] IDX_CAL_CONTROL = 10'h079;
    localparam logic [9:0] IDX_PUMP_WIDTH = 10'h083;
    // Field positions
    localparam int FILTER_ORDER_LSB = 0;
    localparam int OSC_SETTLE_LSB = 0;
    localparam int CLOSED_LOOP_SETTLE_LSB = 2;
    localparam int NARROW_BW_BIT = 0;
    localparam int PUMP_EXTEND_BIT = 7;
    localparam int CAL_START_BIT = 0;
    localparam int CAL_BUSY_BIT = 0;
    localparam int CAL_DONE_BIT = 1;
    // Values after reset
    localparam logic [2:0] FILTER_ORDER_RST = 3'h3;
    localparam logic [1:0] CLOSED_LOOP_SETTLE_RST = 2'h0;
    localparam logic [1:0] OSC_SETTLE_RST = 2'h1;
    localparam logic NARROW_BW_RST = 1'b0;
    localparam logic PUMP_EXTEND_RST = 1'b0;
    // Filter order codes
    localparam logic [2:0] FILTER_SECOND_ORDER = 3'h3;
    localparam logic [2:0] FILTER_THIRD_ORDER = 3'h7;
    // Clock and wait times
    localparam int CLK_PERIOD_NS = 50;
    localparam int LOOP_WAIT0_NS = 30000;
    localparam int LOOP_WAIT1_NS = 300000;
    localparam int LOOP_WAIT2_NS = 30000000;
    localparam int LOOP_WAIT3_NS = 300000000;
    localparam int OSC_WAIT0_NS = 20000;
    localparam int OSC_WAIT1_NS = 400000;
    localparam int OSC_WAIT2_NS = 8000000;
    localparam int OSC_WAIT3_NS = 200000000;
    // Least times round up to whole cycles
    localparam int LOOP_WAIT0_CYC = (LOOP_WAIT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOOP_WAIT1_CYC = (LOOP_WAIT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOOP_WAIT2_CYC = (LOOP_WAIT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOOP_WAIT3_CYC = (LOOP_WAIT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_WAIT0_CYC = (OSC_WAIT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_WAIT1_CYC = (OSC_WAIT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_WAIT2_CYC = (OSC_WAIT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_WAIT3_CYC = (OSC_WAIT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Calibration sequence states
    typedef enum logic [1:0] {CAL_IDLE, CAL_OSC_WAIT, CAL_LOOP_WAIT} plc_cal_state_t;
endpackage : plc_pkg

// ### verification/tb_plc_regs.sv
// Purpose: Self-checking bench for the synthesizer loop control register bank
// Assumes: APB slave answers one cycle after setup; settle counts shortened by parameters
// Notes: Every scenario drives its own transfers and judges the result before returning
`timescale 1ns/100ps
module tb_plc_regs;
    import plc_pkg::*;
    localparam int L1 = 20, L2 = 30, L3 = 40, O1 = 10, O2 = 15, O3 = 25;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, narrow, extend, busy;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [2:0] order;
    logic err;
    int miscompares = 0;
    int comparisons = 0;
    plc_regs #(.LOOP_WAIT1_CYCLES(L1), .LOOP_WAIT2_CYCLES(L2), .LOOP_WAIT3_CYCLES(L3),
        .OSC_WAIT1_CYCLES(O1), .OSC_WAIT2_CYCLES(O2), .OSC_WAIT3_CYCLES(O3)) plc_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .synth_a_filter_order_sel(order), .synth_a_narrow_bandwidth(narrow),
        .synth_b_pump_width_extend(extend), .cal_busy(busy));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    // Holds the request until pready is seen high; a hung slave is left to the watchdog
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Control outputs move in the cycle after the storing edge
    task automatic settle;
        @(posedge pclk);
        #1;
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        check({29'h0, order}, 32'h3);
        check({30'h0, narrow, extend}, 32'h0);
        apb(1'b0, 12'h1d8, 32'h0); check(rd, 32'h03);
        apb(1'b0, 12'h1dc, 32'h0); check(rd, 32'h01);
        apb(1'b0, 12'h1e0, 32'h0); check(rd, 32'h00);
        apb(1'b0, 12'h20c, 32'h0); check(rd, 32'h00);
    endtask : t_reset_values
    task automatic t_filter_order;
        apb(1'b1, 12'h1d8, 32'h7); settle(); check({29'h0, order}, 32'h7);
        apb(1'b1, 12'h1d8, 32'hfffffffb); settle(); check({29'h0, order}, 32'h3);
        apb(1'b0, 12'h1d8, 32'h0); check(rd, 32'h03);
    endtask : t_filter_order
    task automatic t_bandwidth_pump;
        apb(1'b1, 12'h1e0, 32'h1); settle(); check({31'h0, narrow}, 32'h1);
        // Software follows a bandwidth change with matching filter and pump settings
        apb(1'b1, 12'h1d8, 32'h3); apb(1'b1, 12'h20c, 32'h0);
        settle(); check({27'h0, order, narrow, extend}, 32'h0e);
        apb(1'b0, 12'h1e0, 32'h0); check(rd, 32'h01);
        apb(1'b1, 12'h1e0, 32'hfe); settle(); check({31'h0, narrow}, 32'h0);
        apb(1'b0, 12'h1e0, 32'h0); check(rd, 32'h00);
        apb(1'b1, 12'h20c, 32'h80); settle(); check({31'h0, extend}, 32'h1);
        apb(1'b0, 12'h20c, 32'h0); check(rd, 32'h80);
        apb(1'b1, 12'h20c, 32'h7f); settle(); check({31'h0, extend}, 32'h0);
        apb(1'b0, 12'h20c, 32'h0); check(rd, 32'h00);
    endtask : t_bandwidth_pump
    task automatic t_unmapped;
        apb(1'b1, 12'h1d4, 32'h7); check({31'h0, err}, 32'h1);
        apb(1'b0, 12'h000, 32'h0); check({rd[30:0], err}, 32'h1);
        check({29'h0, order}, 32'h3);
    endtask : t_unmapped
    // Busy length per code pair tells both wait fields apart: osc and loop counts differ
    task automatic t_settle_waits;
        int osc_c[4] = '{OSC_WAIT0_CYC, O1, O2, O3};
        int loop_c[4] = '{LOOP_WAIT0_CYC, L1, L2, L3};
        int n;
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, 12'h1dc, 32'hf0 | (c << 2) | ((3 - c) & 3));
            apb(1'b0, 12'h1dc, 32'h0);
            check(rd, (c << 2) | ((3 - c) & 3));
            apb(1'b1, 12'h1e4, 32'h1);
            n = 0;
            @(posedge pclk);
            while (busy === 1'b1 && n < 3000)
            begin
                n++;
                @(posedge pclk);
            end
            check(n, osc_c[(3 - c) & 3] + loop_c[c]);
            apb(1'b0, 12'h1e4, 32'h0);
            check(rd, 32'h02);
        end
    endtask : t_settle_waits
    // A reset in mid-run must bring every field back to its reset value
    task automatic t_mid_reset;
        apb(1'b1, 12'h1dc, 32'h0e);
        apb(1'b1, 12'h1e0, 32'h1);
        apb(1'b1, 12'h20c, 32'h80);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check({27'h0, order, narrow, extend}, 32'h0c);
        apb(1'b0, 12'h1dc, 32'h0); check(rd, 32'h01);
        apb(1'b0, 12'h1e0, 32'h0); check(rd, 32'h00);
        apb(1'b0, 12'h20c, 32'h0); check(rd, 32'h00);
    endtask : t_mid_reset
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial
    begin
        #(20000 * 50);
        miscompares++;
        wrap_up();
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset_values();
        t_filter_order();
        t_bandwidth_pump();
        t_unmapped();
        t_settle_waits();
        t_mid_reset();
        wrap_up();
    end
endmodule : tb_plc_regs
